// ==== core/stfs_pkg.sv ====
// package of constants and carrier types for the supply and thermal supervisor
package stfs_pkg;
   // clock rate and timing figures
   localparam int CLK_HZ = 40000000;
   localparam int SC_FILT_MS = 4;
   localparam int AUX_UV_FILT_US = 7;
   localparam int TSD_DWELL_S = 1;
   localparam int SC_FILT_CYC = (CLK_HZ / 1000) * SC_FILT_MS;
   localparam int AUX_UV_FILT_CYC = (CLK_HZ / 1000000) * AUX_UV_FILT_US;
   localparam int TSD_DWELL_CYC = CLK_HZ * TSD_DWELL_S;
   // transceiver failure field codes
   localparam logic [1:0] FAIL_NONE = 2'h0;
   localparam logic [1:0] FAIL_OVERTEMP = 2'h1;
   localparam int LIN_COUNT = 4;
   // operating modes reported by the mode controller
   typedef enum logic [3:0]
   {
      STFS_MODE_NORMAL = 4'h1,
      STFS_MODE_STOP = 4'h2,
      STFS_MODE_SLEEP = 4'h4,
      STFS_MODE_OTHER = 4'h8
   } stfs_mode_t;
   // supervisor state
   typedef enum logic [2:0]
   {
      STFS_RUN = 3'h1,
      STFS_FS_SHORT = 3'h2,
      STFS_FS_THERMAL = 3'h4
   } stfs_state_t;
   // comparator indications
   typedef struct packed
   {
      logic main_below_rt;
      logic supply_above_to;
      logic aux_below_uv;
      logic aux_hot;
      logic can_hot;
      logic [3:0] lin_hot;
      logic buck_prewarn_hot;
      logic buck_shutdown_hot;
   } stfs_comp_t;
   // software clear strobes
   typedef struct packed
   {
      logic main_short;
      logic main_uv;
      logic buck_short;
      logic aux_uv;
      logic block_ot;
      logic aux_ot;
      logic can_fail;
      logic [3:0] lin_fail;
      logic prewarn;
      logic core_tsd;
   } stfs_clr_t;
endpackage

// ==== core/stfs_filter.sv ====
// condition filter: output rises once input held for a number of cycles
`timescale 1ns/1ps
`default_nettype none
module stfs_filter
#(
   parameter int CYCLES = 4
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cond,
   output var logic hit
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] count;
   ////////////////////////////////////////////////////////////////////////////
   // restart on any drop before expiry
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= '0;
         hit <= 1'b0;
      end
      else if (!cond)
      begin
         count <= '0;
         hit <= 1'b0;
      end
      else if (count == LAST)
      begin
         hit <= 1'b1;
      end
      else
      begin
         count <= count + CW'(1);
      end
   end
   a_filter_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !cond |=> !hit) else $error("filter output outlived its condition");
endmodule
`default_nettype wire

// ==== core/stfs_supervisor.sv ====
// supply short, aux undervoltage and thermal fault supervisor
// Operation
// - main short after filter: fail-safe, buck off
// - short raises fail-safe outputs and three flags
// - short fail-safe left only on wake
// - switcher status bits never change modes
// - filtered aux undervoltage sets sticky flag
// - no aux undervoltage flag during aux ramp
// - block overtemp switches block off, flag
// - block thermal check only while block on
// - aux overtemp clears enables, sets flag
// - aux thermal only normal or stop+watchdog
// - CAN overtemp: transmitter off, failure 01
// - LIN overtemp: transmitter off, failure 01
// - thermal flags sticky until software clear
// - buck prewarn flag while buck on
// - buck shutdown check only in PWM
// - buck shutdown: fail-safe dwell, wakes, outputs
// - shutdown flag cleared only normal, cool
// - fail-safe dwell one second
`timescale 1ns/1ps
`default_nettype none
module stfs_supervisor
   import stfs_pkg::*;
#(
   parameter int SC_CYC = SC_FILT_CYC,
   parameter int UV_CYC = AUX_UV_FILT_CYC,
   parameter int DWELL_CYC = TSD_DWELL_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire stfs_comp_t comp,
   input wire stfs_clr_t clr,
   input wire stfs_mode_t mode,
   input wire logic watchdog_on,
   input wire logic buck_pwm,
   input wire logic aux_ramping,
   input wire logic aux_enable_set,
   input wire logic can_on,
   input wire logic [3:0] lin_on,
   input wire logic wake_can,
   input wire logic [3:0] wake_lin,
   input wire logic wake_input_pin,
   output logic fail_safe,
   output logic buck_enable,
   output logic fail_safe_outputs,
   output logic default_wakes_enable,
   output logic [1:0] aux_output_enable_bits,
   output logic can_tx_enable,
   output logic [3:0] lin_tx_enable,
   output logic main_output_short_flag,
   output logic main_output_undervolt_flag,
   output logic buck_short_flag,
   output logic aux_output_undervolt_flag,
   output logic block_overtemp_flag,
   output logic aux_output_overtemp_flag,
   output logic [1:0] can_failure_field,
   output logic [3:0][1:0] lin_failure_field,
   output logic buck_temp_prewarn_flag,
   output logic core_thermal_shutdown_flag
);
   localparam int DW = $clog2(DWELL_CYC + 1);
   localparam logic [DW-1:0] DWELL_LAST = DW'(DWELL_CYC - 1);
   stfs_comp_t sync1;
   stfs_comp_t cs;
   stfs_state_t state;
   logic [DW-1:0] dwell;
   logic dwell_done;
   logic sc_hit;
   logic uv_hit;
   logic aux_ot_on;
   logic aux_ot_ev;
   logic can_ot_ev;
   logic [3:0] lin_ot_ev;
   logic prewarn_ev;
   logic tsd_ev;
   logic any_wake;
   logic aux_on;
   ////////////////////////////////////////////////////////////////////////////
   // two-stage synchroniser for comparator levels
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1 <= '0;
         cs <= '0;
      end
      else
      begin
         sync1 <= comp;
         cs <= sync1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // filters: main short and aux undervoltage
   stfs_filter #(.CYCLES(SC_CYC)) u_sc_filt
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cond(cs.main_below_rt && cs.supply_above_to && buck_enable),
      .hit(sc_hit)
   );
   stfs_filter #(.CYCLES(UV_CYC)) u_uv_filt
   (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cond(cs.aux_below_uv && !aux_ramping && aux_on),
      .hit(uv_hit)
   );
   ////////////////////////////////////////////////////////////////////////////
   // qualified fault events
   assign aux_on = |aux_output_enable_bits;
   assign aux_ot_on = (mode == STFS_MODE_NORMAL) ||
      ((mode == STFS_MODE_STOP) && watchdog_on);
   assign aux_ot_ev = cs.aux_hot && aux_on && aux_ot_on;
   assign can_ot_ev = cs.can_hot && can_on;
   assign lin_ot_ev = cs.lin_hot & lin_on;
   assign prewarn_ev = cs.buck_prewarn_hot && buck_enable;
   assign tsd_ev = cs.buck_shutdown_hot && buck_enable && buck_pwm;
   assign any_wake = wake_can || (|wake_lin) || wake_input_pin;
   assign dwell_done = (dwell == DWELL_LAST);
   ////////////////////////////////////////////////////////////////////////////
   // supervisor state machine
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= STFS_RUN;
      end
      else
      begin
         case (state)
            STFS_RUN:
            begin
               if (tsd_ev)
               begin
                  state <= STFS_FS_THERMAL;
               end
               else if (sc_hit)
               begin
                  state <= STFS_FS_SHORT;
               end
            end
            STFS_FS_SHORT:
            begin
               if (any_wake)
               begin
                  state <= STFS_RUN;
               end
            end
            STFS_FS_THERMAL:
            begin
               if (dwell_done && any_wake)
               begin
                  state <= STFS_RUN;
               end
            end
            default:
            begin
               state <= STFS_RUN;
            end
         endcase
      end
   end
   // dwell timer counts while thermal fail-safe, saturating
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dwell <= '0;
      end
      else if (state != STFS_FS_THERMAL)
      begin
         dwell <= '0;
      end
      else if (!dwell_done)
      begin
         dwell <= dwell + DW'(1);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // fail-safe actions, driven only by the state machine
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fail_safe <= 1'b0;
         buck_enable <= 1'b1;
         fail_safe_outputs <= 1'b0;
         default_wakes_enable <= 1'b0;
      end
      else
      begin
         fail_safe <= (state != STFS_RUN);
         buck_enable <= (state == STFS_RUN);
         fail_safe_outputs <= (state != STFS_RUN);
         default_wakes_enable <= (state != STFS_RUN);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // aux regulator enables: cleared on overtemp, software re-enables
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aux_output_enable_bits <= 2'h0;
      end
      else if (aux_ot_ev)
      begin
         aux_output_enable_bits <= 2'h0;
      end
      else if (aux_enable_set && !cs.aux_hot)
      begin
         aux_output_enable_bits <= 2'h3;
      end
   end
   // transmitters follow their own block temperature
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         can_tx_enable <= 1'b1;
         lin_tx_enable <= '1;
      end
      else
      begin
         can_tx_enable <= !can_ot_ev;
         lin_tx_enable <= ~lin_ot_ev;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // short-circuit flags; set wins over clear
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         main_output_short_flag <= 1'b0;
         main_output_undervolt_flag <= 1'b0;
         buck_short_flag <= 1'b0;
      end
      else if (state == STFS_RUN && sc_hit && !tsd_ev)
      begin
         main_output_short_flag <= 1'b1;
         main_output_undervolt_flag <= 1'b1;
         buck_short_flag <= 1'b1;
      end
      else
      begin
         if (clr.main_short) main_output_short_flag <= 1'b0;
         if (clr.main_uv) main_output_undervolt_flag <= 1'b0;
         if (clr.buck_short) buck_short_flag <= 1'b0;
      end
   end
   // aux undervoltage flag: only software clears it
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aux_output_undervolt_flag <= 1'b0;
      end
      else if (uv_hit)
      begin
         aux_output_undervolt_flag <= 1'b1;
      end
      else if (clr.aux_uv)
      begin
         aux_output_undervolt_flag <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // thermal flags: sticky, cleared only once cool
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         block_overtemp_flag <= 1'b0;
         aux_output_overtemp_flag <= 1'b0;
         can_failure_field <= FAIL_NONE;
         buck_temp_prewarn_flag <= 1'b0;
         core_thermal_shutdown_flag <= 1'b0;
      end
      else
      begin
         if (aux_ot_ev || can_ot_ev || (|lin_ot_ev))
            block_overtemp_flag <= 1'b1;
         else if (clr.block_ot && !(cs.aux_hot || cs.can_hot || |cs.lin_hot))
            block_overtemp_flag <= 1'b0;
         if (aux_ot_ev)
            aux_output_overtemp_flag <= 1'b1;
         else if (clr.aux_ot && !cs.aux_hot)
            aux_output_overtemp_flag <= 1'b0;
         if (can_ot_ev)
            can_failure_field <= FAIL_OVERTEMP;
         else if (clr.can_fail && !cs.can_hot)
            can_failure_field <= FAIL_NONE;
         if (prewarn_ev)
            buck_temp_prewarn_flag <= 1'b1;
         else if (clr.prewarn && !cs.buck_prewarn_hot)
            buck_temp_prewarn_flag <= 1'b0;
         if (tsd_ev)
            core_thermal_shutdown_flag <= 1'b1;
         else if (clr.core_tsd && !cs.buck_shutdown_hot &&
            mode == STFS_MODE_NORMAL)
            core_thermal_shutdown_flag <= 1'b0;
      end
   end
   // per-LIN failure fields
   for (genvar i = 0; i < LIN_COUNT; i++)
   begin : g_lin
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
         if (!reset_n)
            lin_failure_field[i] <= FAIL_NONE;
         else if (lin_ot_ev[i])
            lin_failure_field[i] <= FAIL_OVERTEMP;
         else if (clr.lin_fail[i] && !cs.lin_hot[i])
            lin_failure_field[i] <= FAIL_NONE;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_short_enters_fs: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (state == STFS_RUN && sc_hit && !tsd_ev) |=> ##1 (fail_safe &&
      !buck_enable && fail_safe_outputs)) else $error("short not acted on");
   a_short_sets_flags: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (state == STFS_RUN && sc_hit && !tsd_ev) |=> (main_output_short_flag &&
      main_output_undervolt_flag && buck_short_flag))
      else $error("short flags missing");
   a_short_needs_wake: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (state == STFS_FS_SHORT && !any_wake) |=> state == STFS_FS_SHORT)
      else $error("left short fail-safe without wake");
   a_uv_flag_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (aux_output_undervolt_flag && !clr.aux_uv) |=> aux_output_undervolt_flag)
      else $error("aux uv flag lost");
   a_aux_ot_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
      aux_ot_ev |=> (aux_output_enable_bits == 2'h0 && aux_output_overtemp_flag))
      else $error("aux overtemp not handled");
   a_can_tx_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
      can_ot_ev |=> (!can_tx_enable && can_failure_field == FAIL_OVERTEMP))
      else $error("can overtemp not handled");
   a_lin_tx_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lin_ot_ev[0] |=> (!lin_tx_enable[0] && lin_failure_field[0] == FAIL_OVERTEMP))
      else $error("lin overtemp not handled");
   a_tsd_pfm_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (state == STFS_RUN && !buck_pwm && !sc_hit) |=> state == STFS_RUN)
      else $error("thermal shutdown in pfm");
   a_tsd_dwell: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (state == STFS_FS_THERMAL && !dwell_done) |=> state == STFS_FS_THERMAL)
      else $error("thermal fail-safe left early");
   a_tsd_flag_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (core_thermal_shutdown_flag && mode != STFS_MODE_NORMAL)
      |=> core_thermal_shutdown_flag) else $error("tsd flag cleared");
   c_short: cover property (@(posedge ref_clk) state == STFS_FS_SHORT);
   c_thermal: cover property (@(posedge ref_clk) state == STFS_FS_THERMAL);
   c_uv: cover property (@(posedge ref_clk) uv_hit);
endmodule
`default_nettype wire

// ==== sim/stfs_comp_model.sv ====
// comparator front model for the supply and thermal supervisor
`timescale 1ns/1ps
`default_nettype none
module stfs_comp_model
   import stfs_pkg::*;
(
   input wire logic ref_clk,
   input wire stfs_comp_t level_req,
   output var stfs_comp_t comp
);
   ////////////////////////////////////////////////////////////////////////
   // analog indications move just after the edge, like a slow comparator
   initial comp = '0;
   always @(posedge ref_clk)
   begin
      comp <= #1 level_req;
   end
endmodule
`default_nettype wire

// ==== sim/stfs_supervisor_bench.sv ====
// self-checking bench for the supply and thermal supervisor
`timescale 1ns/1ps
`default_nettype none
module stfs_supervisor_bench
   import stfs_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   stfs_comp_t fr = '0;
   stfs_comp_t comp;
   stfs_clr_t clr = '0;
   stfs_mode_t mode = STFS_MODE_NORMAL;
   logic watchdog_on = 1'b0;
   logic buck_pwm = 1'b1;
   logic aux_ramping = 1'b0;
   logic aux_set = 1'b0;
   logic can_on = 1'b1;
   logic [3:0] lin_on = 4'hF;
   logic wake_can = 1'b0;
   logic [3:0] wake_lin = 4'h0;
   logic wake_pin = 1'b0;
   logic fs, buck_en, fso, dwe, can_tx, sc_f, uv_f, bs_f, auv_f;
   logic bot_f, aot_f, pw_f, tsd_f;
   logic [1:0] aux_en, can_ff;
   logic [3:0] lin_tx;
   logic [3:0][1:0] lin_ff;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   // clock, run limit
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         num_errors = num_errors + 1;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // far side and device
   stfs_comp_model u_model (.ref_clk(ref_clk), .level_req(fr), .comp(comp));
   stfs_supervisor #(.SC_CYC(8), .UV_CYC(4), .DWELL_CYC(16)) u_dut
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .comp(comp), .clr(clr),
      .mode(mode), .watchdog_on(watchdog_on), .buck_pwm(buck_pwm),
      .aux_ramping(aux_ramping), .aux_enable_set(aux_set),
      .can_on(can_on), .lin_on(lin_on), .wake_can(wake_can),
      .wake_lin(wake_lin), .wake_input_pin(wake_pin), .fail_safe(fs),
      .buck_enable(buck_en), .fail_safe_outputs(fso),
      .default_wakes_enable(dwe), .aux_output_enable_bits(aux_en),
      .can_tx_enable(can_tx), .lin_tx_enable(lin_tx),
      .main_output_short_flag(sc_f), .main_output_undervolt_flag(uv_f),
      .buck_short_flag(bs_f), .aux_output_undervolt_flag(auv_f),
      .block_overtemp_flag(bot_f), .aux_output_overtemp_flag(aot_f),
      .can_failure_field(can_ff), .lin_failure_field(lin_ff),
      .buck_temp_prewarn_flag(pw_f), .core_thermal_shutdown_flag(tsd_f)
   );
   ////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input logic [3:0] seen, input logic [3:0] exp,
      input string msg);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic pulse_clr(input stfs_clr_t c);
      clr = c;
      cyc(1);
      clr = '0;
      cyc(4);
   endtask
   task automatic do_reset();
      fr = '0;
      mode = STFS_MODE_NORMAL;
      reset_n = 1'b0;
      cyc(4);
      reset_n = 1'b1;
      cyc(1);
   endtask
   task automatic aux_on();
      aux_set = 1'b1;
      cyc(1);
      aux_set = 1'b0;
      cyc(2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      do_reset();
      check({fs, fso, buck_en, can_tx}, 4'h3, "reset outputs");
      check(lin_tx, 4'hF, "reset lin tx");
      check({sc_f, auv_f, bot_f, tsd_f}, 4'h0, "reset flags");
   endtask
   task automatic t_short();
      stfs_clr_t c;
      do_reset();
      fr.main_below_rt = 1'b1;
      cyc(20);
      check(fs, 1'b0, "short without supply");
      fr.supply_above_to = 1'b1;
      cyc(6);
      fr.main_below_rt = 1'b0;
      cyc(1);
      fr.main_below_rt = 1'b1;
      cyc(6);
      check(fs, 1'b0, "filter restart");
      cyc(14);
      check({fs, buck_en, fso}, 4'h5, "short shutdown");
      check({sc_f, uv_f, bs_f}, 4'h7, "short flags");
      fr = '0;
      cyc(10);
      check(fs, 1'b1, "stays without wake");
      wake_pin = 1'b1;
      cyc(2);
      wake_pin = 1'b0;
      cyc(4);
      check(fs, 1'b0, "wake leaves");
      check({sc_f, bs_f}, 4'h3, "flags kept");
      c = '0;
      c.main_short = 1'b1;
      c.buck_short = 1'b1;
      c.main_uv = 1'b1;
      pulse_clr(c);
      check({sc_f, uv_f, bs_f}, 4'h0, "short flags cleared");
   endtask
   task automatic t_can_lin();
      stfs_clr_t c;
      do_reset();
      fr.can_hot = 1'b1;
      cyc(6);
      check({can_tx, bot_f}, 4'h1, "can off");
      check(can_ff, FAIL_OVERTEMP, "can failure");
      check(lin_tx, 4'hF, "lin untouched");
      c = '0;
      c.can_fail = 1'b1;
      pulse_clr(c);
      check(can_ff, FAIL_OVERTEMP, "clear refused hot");
      fr.can_hot = 1'b0;
      cyc(6);
      check({can_tx, bot_f}, 4'h3, "can back, flag kept");
      pulse_clr(c);
      check(can_ff, FAIL_NONE, "can cleared");
      for (int i = 0; i < LIN_COUNT; i++)
      begin
         fr.lin_hot[i] = 1'b1;
         cyc(6);
         check(lin_tx, ~(4'h1 << i), "lin off");
         check(lin_ff[i], FAIL_OVERTEMP, "lin failure");
         fr.lin_hot[i] = 1'b0;
         cyc(6);
         check({lin_tx[i], lin_ff[i]}, 4'h5, "lin back, kept");
         c = '0;
         c.lin_fail[i] = 1'b1;
         pulse_clr(c);
         check(lin_ff[i], FAIL_NONE, "lin cleared");
      end
      lin_on[3] = 1'b0;
      fr.lin_hot[3] = 1'b1;
      cyc(6);
      check({lin_tx[3], lin_ff[3]}, 4'h4, "off block not checked");
      fr.lin_hot[3] = 1'b0;
      lin_on[3] = 1'b1;
   endtask
   task automatic t_aux();
      stfs_clr_t c;
      do_reset();
      aux_on();
      check(aux_en, 4'h3, "aux enabled");
      mode = STFS_MODE_SLEEP;
      fr.aux_hot = 1'b1;
      cyc(6);
      check({aux_en, aot_f}, 4'h6, "aux thermal off in sleep");
      mode = STFS_MODE_NORMAL;
      cyc(6);
      check({aux_en, aot_f, bot_f}, 4'h3, "aux overtemp");
      fr.aux_hot = 1'b0;
      cyc(6);
      check(aux_en, 4'h0, "aux stays off");
      c = '0;
      c.aux_ot = 1'b1;
      c.block_ot = 1'b1;
      pulse_clr(c);
      check({aot_f, bot_f}, 4'h0, "thermal flags cleared cool");
      aux_on();
      check(aux_en, 4'h3, "aux re-enabled");
      mode = STFS_MODE_STOP;
      fr.aux_hot = 1'b1;
      cyc(6);
      check({aux_en, aot_f}, 4'h6, "aux thermal off in stop");
      watchdog_on = 1'b1;
      cyc(6);
      check({aux_en, aot_f}, 4'h1, "aux overtemp stop+watchdog");
      pulse_clr(c);
      check(aot_f, 1'b1, "aux flag clear refused hot");
      fr.aux_hot = 1'b0;
      mode = STFS_MODE_NORMAL;
      watchdog_on = 1'b0;
      cyc(6);
      aux_on();
      check(aux_en, 4'h3, "aux on again");
      aux_ramping = 1'b1;
      fr.aux_below_uv = 1'b1;
      cyc(12);
      check(auv_f, 1'b0, "no flag during ramp");
      aux_ramping = 1'b0;
      cyc(12);
      check(auv_f, 1'b1, "aux undervoltage");
      fr.aux_below_uv = 1'b0;
      cyc(6);
      check(auv_f, 1'b1, "uv flag sticky");
      c = '0;
      c.aux_uv = 1'b1;
      pulse_clr(c);
      check(auv_f, 1'b0, "uv cleared");
   endtask
   task automatic t_buck_thermal();
      stfs_clr_t c;
      do_reset();
      fr.buck_prewarn_hot = 1'b1;
      cyc(6);
      check({pw_f, fs}, 4'h2, "prewarn, no mode change");
      c = '0;
      c.prewarn = 1'b1;
      pulse_clr(c);
      check(pw_f, 1'b1, "prewarn clear refused");
      fr.buck_prewarn_hot = 1'b0;
      cyc(4);
      pulse_clr(c);
      check(pw_f, 1'b0, "prewarn cleared");
      buck_pwm = 1'b0;
      fr.buck_shutdown_hot = 1'b1;
      cyc(8);
      check({fs, tsd_f}, 4'h0, "no shutdown in pfm");
      buck_pwm = 1'b1;
      cyc(6);
      check({fs, tsd_f, dwe, fso}, 4'hF, "thermal fail-safe");
      fr.buck_shutdown_hot = 1'b0;
      wake_can = 1'b1;
      cyc(2);
      wake_can = 1'b0;
      cyc(2);
      check(fs, 1'b1, "dwell not over");
      cyc(20);
      wake_lin[0] = 1'b1;
      cyc(2);
      wake_lin[0] = 1'b0;
      cyc(4);
      check(fs, 1'b0, "left after dwell");
      mode = STFS_MODE_STOP;
      c = '0;
      c.core_tsd = 1'b1;
      pulse_clr(c);
      check(tsd_f, 1'b1, "clear outside normal");
      mode = STFS_MODE_NORMAL;
      pulse_clr(c);
      check(tsd_f, 1'b0, "cleared in normal");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // closing report
   task automatic summarize();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      t_reset();
      t_short();
      t_can_lin();
      t_aux();
      t_buck_thermal();
      summarize();
   end
endmodule
`default_nettype wire
